/* File: design/drrf_ctrl.sv */
// ddr3 refresh and self-refresh controller with ahb-lite registers
//
// Chosen here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - every write strobe edge meets timing
// - strobe to clock skew met each edge
// - bl8 via mode bits or a12 high
// - precharge all, wait trp before refresh
// - only nop or des during trfc
// - one refresh command per needed refresh
// - at most eight postponed, gap nine trefi
// - at most eight pulled in credited
// - flush postponed refreshes before self-refresh
// - banks precharged, odt off before sre
// - hold cke low during self-refresh
// - stay in self-refresh at least tcke
// - clock stop after tcksre, restart tcksrx
// - exit with cke high, wait txs, txsdll (code skips the txsdll wait when sr_req is set again with CTRL_DLL_ON clear)
// - nop during exit, cke high, odt low
// - one refresh after exit before re-entry
module drrf_ctrl
	import drrf_pkg::*;
#(
	parameter int TREFI_CYC = TREFI_CK,
	parameter int TXSDLL_CYC = TXSDLL_CK
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic ddr_cke,
	output logic ddr_ck_en,
	output logic ddr_odt,
	output logic ddr_a12,
	output logic ddr_a10,
	output drrf_cmd_s ddr_cmd
);
	initial begin
		if (TREFI_CYC < TRFC_CK + 2 || TREFI_CYC > 65535 || TXSDLL_CYC < 1)
			$error("drrf_ctrl: unsupported timing parameter");
	end
	// ahb slave: zero wait state, always okay
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	logic [4:0] ctrl_q;
	logic [15:0] trefi_q;
	logic [15:0] refcnt_q;
	wire acc = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else begin
			wr_pend_q <= acc && hwrite;
			wr_addr_q <= haddr;
		end
	end
	wire wr_ctrl = wr_pend_q && wr_addr_q == REG_CTRL;
	wire wr_trefi = wr_pend_q && wr_addr_q == REG_TREFI;
	// controller state
	drrf_state_e st_q;
	logic [9:0] tmr_q;
	logic [15:0] iv_q;
	logic signed [4:0] debt_q;
	logic odt_q;
	logic [3:0] odt_low_q;
	logic need_ref_q;
	logic in_sr;
	wire tmr_done = tmr_q == 10'h000;
	wire iv_tick = iv_q == 16'h0000;
	wire is_ref = st_q == ST_REF && ddr_cmd == CMD_REF;
	wire sr_req = ctrl_q[CTRL_SR_REQ] && ctrl_q[CTRL_EN];
	wire odt_clear = odt_low_q >= 4'(ODT_OFF_CK);
	wire want_ref = debt_q > 0 || (ctrl_q[CTRL_PULLIN] && debt_q > -DEBT_MAX)
		|| need_ref_q || (sr_req && debt_q > -1);
	assign in_sr = st_q == ST_SR || st_q == ST_CKRS;
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (haddr)
			REG_CTRL: rd_mux = {27'h000_0000, ctrl_q};
			REG_STAT: rd_mux = {16'h0000, 5'h00, st_q, 5'h00, in_sr, ddr_cke,
				debt_q[4]};
			REG_TREFI: rd_mux = {16'h0000, trefi_q};
			REG_CNT: rd_mux = {11'h000, debt_q, refcnt_q};
			default: rd_mux = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
			ctrl_q <= 5'h00;
			trefi_q <= 16'h0000;
		end else begin
			if (acc && !hwrite)
				hrdata <= rd_mux;
			if (wr_ctrl)
				ctrl_q <= hwdata[4:0];
			if (wr_trefi)
				trefi_q <= hwdata[15:0];
		end
	end
	// interval tick drives the debt counter
	wire [15:0] iv_load = trefi_q != 16'h0000 ? trefi_q : 16'(TREFI_CYC);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			iv_q <= 16'h0000;
			debt_q <= 5'sd0;
			refcnt_q <= 16'h0000;
		end else begin
			iv_q <= (iv_tick || !ctrl_q[CTRL_EN]) ? iv_load - 16'h0001
				: iv_q - 16'h0001;
			// saturating signed debt, sr counts as covered
			if (ctrl_q[CTRL_EN] && !in_sr) begin
				if (iv_tick && !is_ref && debt_q < 5'(DEBT_MAX))
					debt_q <= debt_q + 5'sd1;
				else if (is_ref && !iv_tick && debt_q > -5'(DEBT_MAX))
					debt_q <= debt_q - 5'sd1;
			end
			if (is_ref)
				refcnt_q <= refcnt_q + 16'h0001;
		end
	end
	// odt low tracking so sre waits odtl plus one clock
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			odt_low_q <= 4'h0;
		end else if (odt_q) begin
			odt_low_q <= 4'h0;
		end else if (!odt_clear) begin
			odt_low_q <= odt_low_q + 4'h1;
		end
	end
	// sequencer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q <= ST_IDLE;
			tmr_q <= 10'h000;
			ddr_cmd <= CMD_DES;
			ddr_cke <= 1'b1;
			ddr_ck_en <= 1'b1;
			odt_q <= 1'b0;
			need_ref_q <= 1'b0;
			ddr_a10 <= 1'b0;
			ddr_a12 <= 1'b0;
		end else begin
			ddr_cmd <= CMD_NOP;
			ddr_a10 <= 1'b0;
			// on-the-fly bl8 select by a12
			// no write burst is ever issued here, so strobe timing holds
			ddr_a12 <= ctrl_q[CTRL_BL8];
			if (!tmr_done)
				tmr_q <= tmr_q - 10'h001;
			unique case (st_q)
				ST_IDLE: begin
					odt_q <= 1'b0;
					if (tmr_done && ctrl_q[CTRL_EN] && (want_ref || sr_req)) begin
						// precharge all before any refresh or sre
						ddr_cmd <= CMD_PRE;
						ddr_a10 <= 1'b1;
						tmr_q <= 10'(TRP_CK);
						st_q <= ST_PRE;
					end
				end
				ST_PRE: if (tmr_done && odt_clear) begin
					if (want_ref) begin
						ddr_cmd <= CMD_REF;
						tmr_q <= 10'(TRFC_CK);
						need_ref_q <= 1'b0;
						st_q <= ST_REF;
					end else begin
						ddr_cmd <= CMD_REF;
						ddr_cke <= 1'b0;
						tmr_q <= 10'(TCKSRE_CK > TCKE_CK ? TCKSRE_CK : TCKE_CK);
						st_q <= ST_SRE;
					end
				end
				ST_REF: if (tmr_done) begin
					st_q <= ST_IDLE; // nop only across trfc
				end
				ST_SRE: if (tmr_done) begin
					ddr_ck_en <= 1'b0;
					st_q <= ST_SR;
				end
				ST_SR: if (!sr_req) begin
					ddr_ck_en <= 1'b1;
					tmr_q <= 10'(TCKSRX_CK);
					st_q <= ST_CKRS;
				end
				ST_CKRS: if (tmr_done) begin
					ddr_cke <= 1'b1;
					tmr_q <= 10'(TXS_CK);
					need_ref_q <= 1'b1;
					st_q <= ST_XS;
				end
				ST_XS: if (tmr_done) begin
					tmr_q <= 10'(TXSDLL_CYC - TXS_CK);
					st_q <= ST_XDLL;
				end
				ST_XDLL: if (tmr_done || (sr_req && !ctrl_q[CTRL_DLL_ON])) begin
					st_q <= ST_IDLE;
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end
	assign ddr_odt = odt_q;

	// checks
	a_ref_spacing: assert property (@(posedge hclk) disable iff (!hresetn)
		ddr_cmd == CMD_REF && ddr_cke |=> ddr_cmd == CMD_NOP [*2])
		else $error("command during trfc");
	a_ref_after_pre: assert property (@(posedge hclk) disable iff (!hresetn)
		ddr_cmd == CMD_REF |-> $past(st_q) == ST_PRE)
		else $error("refresh without precharge");
	a_cke_hold_sr: assert property (@(posedge hclk) disable iff (!hresetn)
		st_q == ST_SR |-> !ddr_cke)
		else $error("cke high in self-refresh");
	a_sre_debt: assert property (@(posedge hclk) disable iff (!hresetn)
		ddr_cmd == CMD_REF && !ddr_cke |-> debt_q <= 0)
		else $error("sre with postponed refresh");
	a_debt_range: assert property (@(posedge hclk) disable iff (!hresetn)
		debt_q <= 8 && debt_q >= -8)
		else $error("debt out of range");
	a_odt_sre: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(ddr_cke) |-> !ddr_odt && !$past(ddr_odt))
		else $error("odt on at sre");
	a_exit_nop: assert property (@(posedge hclk) disable iff (!hresetn)
		st_q == ST_XS |-> ddr_cmd == CMD_NOP && ddr_cke && !ddr_odt)
		else $error("command during txs");
	a_sr_min: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(ddr_cke) |=> !ddr_cke [*2])
		else $error("self-refresh too short");
	a_ck_stable: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(ddr_cke) |-> ddr_ck_en && $past(ddr_ck_en, 2))
		else $error("clock not stable at exit");
	c_refresh: cover property (@(posedge hclk) disable iff (!hresetn)
		ddr_cmd == CMD_REF && ddr_cke);
	c_sr_cycle: cover property (@(posedge hclk) disable iff (!hresetn)
		st_q == ST_XDLL ##1 st_q == ST_IDLE);
	c_debt_full: cover property (@(posedge hclk) disable iff (!hresetn)
		debt_q == 8);
	c_pullin: cover property (@(posedge hclk) disable iff (!hresetn)
		debt_q == -8);
endmodule
`default_nettype wire

/* File: design/drrf_pkg.sv */
// package for the ddr3 refresh and self-refresh controller
package drrf_pkg;
	// command encodings {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam logic [3:0] CMD_DES = 4'hF;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_PRE = 4'h2;
	// own registers, byte addresses
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [7:0] REG_TREFI = 8'h08;
	localparam logic [7:0] REG_CNT = 8'h0C;
	// control fields
	localparam int CTRL_EN = 0;
	localparam int CTRL_SR_REQ = 1;
	localparam int CTRL_PULLIN = 2;
	localparam int CTRL_DLL_ON = 3;
	localparam int CTRL_BL8 = 4;
	// timing, ns or clocks as printed or chosen, clock period in ps
	localparam int CLK_PS = 8000;
	localparam int TRP_NS = 14;
	localparam int TRFC_NS = 160;
	localparam int TREFI_NS = 7800;
	localparam int TXS_NS = 170;
	localparam int TCKE_NS = 6;
	localparam int TCKSRE_NS = 10;
	localparam int TCKSRX_NS = 10;
	localparam int TXSDLL_CK = 512;
	localparam int ODTL_CK = 6;
	localparam int TRP_CK = (TRP_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int TRFC_CK = (TRFC_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int TREFI_CK = (TREFI_NS * 1000) / CLK_PS;
	localparam int TXS_CK = (TXS_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int TCKE_CK = (TCKE_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int TCKSRE_CK = (TCKSRE_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int TCKSRX_CK = (TCKSRX_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int ODT_OFF_CK = ODTL_CK + 1;
	localparam int DEBT_MAX = 8;
	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
	} drrf_cmd_s;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_PRE = 3'b001,
		ST_REF = 3'b011,
		ST_SRE = 3'b010,
		ST_SR = 3'b110,
		ST_CKRS = 3'b111,
		ST_XS = 3'b101,
		ST_XDLL = 3'b100
	} drrf_state_e;
endpackage

/* File: verif/drrf_dev.sv */
// device model facing the refresh controller pins
`timescale 1ns/1ps
`default_nettype none
module drrf_dev
	import drrf_pkg::*;
#(
	parameter int TREFI_CYC = 40,
	parameter int TXSDLL_CYC = 30
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire drrf_cmd_s cmd,
	input wire logic cke,
	input wire logic ck_en,
	input wire logic odt,
	output int refs,
	output int errs,
	output logic in_sr
);
	logic cke_q;
	logic dll_on;
	logic owe;
	int pre_c;
	int ref_c;
	int sr_c;
	int ck_c;
	int xs;
	wire logic is_ref = cmd == CMD_REF;
	wire logic quiet = cmd == CMD_NOP || cmd == CMD_DES;
	// no data path is modelled: no write reaches the array to corrupt
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cke_q <= 1'b1;
			dll_on <= 1'b1;
			owe <= 1'b0;
			in_sr <= 1'b0;
			refs <= 0;
			errs <= 0;
			pre_c <= TRP_CK;
			ref_c <= TRFC_CK;
			sr_c <= 0;
			ck_c <= 0;
			xs <= TXSDLL_CYC;
		end else begin
			cke_q <= cke;
			pre_c <= cmd == CMD_PRE ? 0 : pre_c + 1;
			ck_c <= ck_en ? ck_c + 1 : 0;
			xs <= xs + 1;
			if (in_sr) begin
				// cke and ck_en are looked at here
				sr_c <= sr_c + 1;
				if (!ck_en && sr_c + 1 < TCKSRE_CK ||
						cke && (sr_c + 1 < TCKE_CK || ck_c < TCKSRX_CK))
					errs <= errs + 1;
				if (cke) begin
					in_sr <= 1'b0;
					dll_on <= 1'b1;
					owe <= 1'b1;
					ref_c <= 0;
					xs <= 0;
				end
			end else if (is_ref && cke_q && !cke) begin
				// entry
				if (pre_c + 1 < TRP_CK || odt || owe || xs + 1 < TXS_CK)
					errs <= errs + 1;
				in_sr <= 1'b1;
				sr_c <= 0;
				dll_on <= 1'b0;
				refs <= refs + 1; // at once, inside tcke
			end else begin
				// rows from own counter
				if (!quiet && (ref_c + 1 < TRFC_CK || xs + 1 < TXS_CK) ||
						xs + 1 < TXSDLL_CYC && (!cke || odt) ||
						is_ref && pre_c + 1 < TRP_CK ||
						ref_c > 9 * TREFI_CYC && refs > 0)
					errs <= errs + 1;
				ref_c <= is_ref ? 0 : ref_c + 1;
				refs <= refs + int'(is_ref);
				if (is_ref)
					owe <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

/* File: verif/tb_drrf_ctrl.sv */
// testbench for the refresh and self-refresh controller
`timescale 1ns/1ps
`default_nettype none
module tb_drrf_ctrl
	import drrf_pkg::*;
;
	logic hclk, hresetn, hsel, hwrite, hreadyout, cke, ck_en, odt, a12;
	logic [7:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, r, c0;
	logic in_sr, hresp;
	wire logic hready = hreadyout;
	drrf_cmd_s cmd;
	int refs, errs, bad_count, tests_run;
	drrf_ctrl #(.TREFI_CYC(40), .TXSDLL_CYC(30)) dut (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ddr_cke(cke),
		.ddr_ck_en(ck_en), .ddr_odt(odt), .ddr_a12(a12), .ddr_a10(),
		.ddr_cmd(cmd));
	drrf_dev #(.TREFI_CYC(40), .TXSDLL_CYC(30)) dev (.clk(hclk),
		.rst_n(hresetn), .cmd(cmd), .cke(cke), .ck_en(ck_en), .odt(odt),
		.refs(refs), .errs(errs), .in_sr(in_sr));
	task automatic conclude;
		$display("tests_run %0d bad_count %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s exp %h seen %h", nm, exp, got);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge hclk);
	endtask
	// a stuck hready would hang the bus, so give up after a bound
	task automatic rdy;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < 64);
		if (hready !== 1'b1) begin
			bad_count++;
			conclude();
		end
	endtask
	task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		rdy();
		htrans <= 2'b00;
		hwdata <= d;
		rdy();
		r = hrdata;
	endtask
	task automatic till(logic v);
		int n;
		for (n = 0; in_sr !== v; n++) begin
			if (n > 999) begin
				bad_count++;
				conclude();
			end
			@(posedge hclk);
		end
	endtask
	task automatic t_reset;
		chk("cmd", 32'(cmd), 32'(CMD_NOP));
		chk("pins", {29'h0, cke, ck_en, odt}, 32'h0000_0006);
		chk("hresp", 32'(hresp), 32'h0000_0000);
		xfer(1'b0, REG_STAT, 0);
		chk("stat", r, 32'h0000_0002);
		xfer(1'b1, 8'h10, 32'hFFFF_FFFF);
		xfer(1'b0, 8'h10, 0);
		chk("unmapped", r, 0);
		$display("reset test done");
	endtask
	task automatic t_refresh;
		xfer(1'b1, REG_CTRL, 32'h0000_0001);
		for (int i = 0; i < 2; i++) begin
			xfer(1'b1, REG_TREFI, i ? 0 : 30);
			xfer(1'b0, REG_CNT, 0);
			c0 = r;
			tick(i ? 400 : 300);
			xfer(1'b0, REG_CNT, 0);
			chk("refs", 32'(r[15:0] - c0[15:0] inside {[9:11]}), 1);
		end
		$display("refresh test done");
	endtask
	task automatic t_pullin;
		xfer(1'b1, REG_CTRL, 32'h0000_0005);
		tick(800);
		xfer(1'b0, REG_CNT, 0);
		// a tick may just have lifted the debt off its floor
		chk("debt", 32'(r[20:16] inside {5'h18, 5'h19}), 1);
		xfer(1'b1, REG_CTRL, 32'h0000_0001);
		tick(400);
		chk("model", errs, 0);
		$display("pull-in test done");
	endtask
	// second pass re-enters at once, so the extra refresh must come first
	task automatic t_sr;
		for (int i = 0; i < 2; i++) begin
			xfer(1'b1, REG_CTRL, 32'h0000_0013);
			till(1'b1);
			chk("sre", {30'h0, cke, odt}, 0);
			chk("a12", 32'(a12), 1);
			tick(20);
			chk("ck_en", 32'(ck_en), 0);
			xfer(1'b0, REG_STAT, 0);
			chk("in_sr", 32'(r[2]), 1);
			xfer(1'b1, REG_CTRL, 32'h0000_0011);
			till(1'b0);
			chk("cke", 32'(cke), 1);
		end
		tick(100);
		chk("model", errs, 0);
		$display("self-refresh test done");
	endtask
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0000_0000;
		bad_count = 0;
		tests_run = 0;
		tick(10);
		chk("des", 32'(cmd), 32'(CMD_DES));
		hresetn <= 1'b1;
		tick(2);
		t_reset();
		t_refresh();
		t_pullin();
		t_sr();
		conclude();
	end
endmodule
`default_nettype wire
